// File: hdl/usb_bdt_pkg.sv
package usb_bdt_pkg;

	// ----------------------------------------------------------------
	// control bit positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODULE_ENABLE_BIT = 0;
	localparam int CTRL_MODULE_POWER_BIT  = 1;
	localparam int CTRL_HOST_ROLE_BIT     = 3;
	localparam int OTG_CTRL_ENABLE_BIT    = 2;
	localparam int OTG_DMINUS_PD_BIT      = 4;
	localparam int OTG_DPLUS_PD_BIT       = 5;
	localparam int OTG_DPLUS_PU_BIT       = 7;
	localparam int CFG_PINGPONG_LSB       = 0;
	localparam int STAT_SRC_EP_LSB        = 4;

	// ----------------------------------------------------------------
	// descriptor status word layout
	// ----------------------------------------------------------------
	localparam int DESC_OWN_BIT    = 15;
	localparam int DESC_TOGGLE_BIT = 14;
	localparam int DESC_PID_LSB    = 10;
	localparam int DESC_COUNT_LSB  = 0;
	localparam int DESC_COUNT_W    = 10;

	// ----------------------------------------------------------------
	// table geometry
	// ----------------------------------------------------------------
	localparam int          DESC_INDEX_W   = 6;
	localparam int          DESC_BYTES_LOG = 2;
	localparam int          TABLE_ALIGN_W  = 9;
	localparam logic [7:0]  BASE_RESET     = 8'h00;
	localparam logic [15:0] DMA_ADDR_RESET = 16'h0000;
	localparam logic [1:0]  DESC_STATUS_OFS = 2'h0;
	localparam logic [1:0]  DESC_BUFADR_OFS = 2'h2;

	typedef enum logic [1:0] {
		PP_NONE    = 2'b00,
		PP_EP0_RX  = 2'b01,
		PP_ALL     = 2'b10,
		PP_ALL_BUT = 2'b11
	} pingpong_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_STATUS = 2'b01,
		ST_BUFADR = 2'b10,
		ST_DONE   = 2'b11
	} fetch_state_t;

endpackage : usb_bdt_pkg

// File: hdl/usb_bdt_if.sv
`timescale 1ns/1ps
// joins the engine end (device) and the software/partner end (other)
interface usb_bdt_if;
	logic        module_enable_bit;
	logic        module_power_bit;
	logic        host_role_enable;
	logic        otg_resistor_ctrl_enable;
	logic        dplus_pullup_ctrl;
	logic        dplus_pulldown_ctrl;
	logic        dminus_pulldown_ctrl;
	logic        vbus_session_valid;
	logic [7:0]  table_base_pointer;
	logic [1:0]  pingpong_mode;
	logic        xfer_req;
	logic [3:0]  xfer_ep;
	logic        xfer_tx;
	logic        xfer_odd;
	logic [3:0]  token_dest_ep;
	logic [3:0]  rx_src_ep;
	logic        mem_req;
	logic        mem_we;
	logic [15:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic        xfer_done;
	logic [15:0] done_status;
	logic [3:0]  done_src_ep;
	logic [3:0]  done_dest_ep;
	logic [15:0] done_buf_addr;
	logic        done_owned_by_sw;

	modport device (
		input  module_enable_bit, module_power_bit, host_role_enable,
		input  otg_resistor_ctrl_enable, dplus_pullup_ctrl, dplus_pulldown_ctrl,
		input  dminus_pulldown_ctrl, vbus_session_valid, table_base_pointer,
		input  pingpong_mode, xfer_req, xfer_ep, xfer_tx, xfer_odd,
		input  token_dest_ep, rx_src_ep, mem_rdata,
		output mem_req, mem_we, mem_addr, mem_wdata, xfer_done, done_status,
		output done_src_ep, done_dest_ep, done_buf_addr, done_owned_by_sw
	);

	modport other (
		output module_enable_bit, module_power_bit, host_role_enable,
		output otg_resistor_ctrl_enable, dplus_pullup_ctrl, dplus_pulldown_ctrl,
		output dminus_pulldown_ctrl, vbus_session_valid, table_base_pointer,
		output pingpong_mode, xfer_req, xfer_ep, xfer_tx, xfer_odd,
		output token_dest_ep, rx_src_ep, mem_rdata,
		input  mem_req, mem_we, mem_addr, mem_wdata, xfer_done, done_status,
		input  done_src_ep, done_dest_ep, done_buf_addr, done_owned_by_sw
	);
endinterface : usb_bdt_if

// File: hdl/bdt_index_map.sv
`timescale 1ns/1ps
// combinational descriptor index for endpoint, direction and ping-pong bank
module bdt_index_map
	import usb_bdt_pkg::*;
(
	input  wire logic       [3:0] ep,
	input  wire logic             tx,
	input  wire logic             odd,
	input  wire pingpong_mode_t   mode,
	output logic            [5:0] index
);
	// ----------------------------------------------------------------
	// mapping per buffering mode
	// ----------------------------------------------------------------
	always_comb begin
		case (mode)
			PP_NONE: index = {1'b0, ep, tx};
			PP_EP0_RX: begin
				if (ep == 4'h0 && !tx) index = {5'h00, odd};
				else index = 6'({1'b0, ep, tx} + 6'h01);
			end
			PP_ALL: index = {ep, tx, odd};
			default: begin
				if (ep == 4'h0) index = {5'h00, tx};
				else index = 6'({ep, tx, odd} - 6'h02);
			end
		endcase
	end
endmodule : bdt_index_map

// File: hdl/usb_bdt_engine.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// descriptor fetch engine and bus resistor control
// ----------------------------------------------------------------
// a transfer walks idle, status read, buffer word read, write-back and done.
// a request is taken only while idle; one that arrives while busy is dropped,
// so the requester must wait for done or skipped before asking again.
// the status word is read first so that a descriptor still held by software
// costs one read and is never written back.
// memory answers on the edge after each request; there are no wait states,
// so a slower memory would need a stall input that this block lacks.
module usb_bdt_engine
	import usb_bdt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	usb_bdt_if.device        bus,
	input  wire logic [9:0]  xfer_actual_count,
	input  wire logic [3:0]  xfer_pid,
	output logic             dplus_pullup_on,
	output logic             dplus_pulldown_on,
	output logic             dminus_pulldown_on,
	output logic             xfer_busy,
	output logic             xfer_skipped
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic         pu;
		logic         dp_pd;
		logic         dm_pd;
		fetch_state_t st;
		logic [7:0]   base;
		logic [5:0]   idx;
		logic [15:0]  status;
		logic [15:0]  buf_addr;
		logic [3:0]   src_ep;
		logic [3:0]  dest_ep;
		logic         mem_req;
		logic         mem_we;
		logic [15:0]  mem_addr;
		logic [15:0]  mem_wdata;
		logic         done;
		logic         skipped;
		logic         busy;
	} eng_t;

	// whole engine state in one register, next value built below
	eng_t       s_q;
	eng_t       s_d;
	logic [3:0] sel_ep;
	logic [5:0] sel_idx;

	// host role always resolves to endpoint zero descriptors
	assign sel_ep = bus.host_role_enable ? 4'h0 : bus.xfer_ep;

	bdt_index_map u_map (
		.ep    (sel_ep),
		.tx    (bus.xfer_tx),
		.odd   (bus.xfer_odd),
		.mode  (pingpong_mode_t'(bus.pingpong_mode)),
		.index (sel_idx)
	);

	// byte address of one word of a descriptor inside the aligned table;
	// bit 0 of the base is dropped so the table always sits on 512 bytes
	function automatic logic [15:0] desc_addr(
		input logic [7:0] base,
		input logic [5:0] idx,
		input logic [1:0] ofs
	);
		desc_addr = {base[7:1], 9'h000} | {7'h00, 1'b0, idx, ofs};
	endfunction : desc_addr

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d         = s_q;
		s_d.done    = 1'b0;
		s_d.skipped = 1'b0;
		s_d.mem_req = 1'b0;
		s_d.mem_we  = 1'b0;

		// ------------------------------------------------------------
		// bus resistors: otg register overrides direct control bits
		// ------------------------------------------------------------
		if (bus.otg_resistor_ctrl_enable) begin
			s_d.pu    = bus.dplus_pullup_ctrl;
			s_d.dp_pd = bus.dplus_pulldown_ctrl;
			s_d.dm_pd = bus.dminus_pulldown_ctrl;
		end else begin
			s_d.pu    = bus.module_enable_bit & bus.module_power_bit;
			s_d.dp_pd = bus.host_role_enable;
			s_d.dm_pd = bus.host_role_enable;
		end
		// back-drive protection wins over firmware in every mode
		if (!bus.vbus_session_valid) s_d.pu = 1'b0;

		// ------------------------------------------------------------
		// descriptor fetch
		// ------------------------------------------------------------
		case (s_q.st)
			ST_IDLE: begin
				// latch the request; these fields stand until the next take
				if (bus.xfer_req) begin
					s_d.base     = bus.table_base_pointer;
					s_d.idx      = sel_idx;
					s_d.src_ep   = bus.rx_src_ep;
					s_d.dest_ep  = bus.token_dest_ep;
					s_d.mem_req  = 1'b1;
					s_d.mem_addr = desc_addr(bus.table_base_pointer, sel_idx, DESC_STATUS_OFS);
					s_d.st       = ST_STATUS;
				end
			end
			ST_STATUS: begin
				s_d.status = bus.mem_rdata;
				if (!bus.mem_rdata[DESC_OWN_BIT]) begin
					// software still holds it: leave descriptor untouched
					s_d.skipped = 1'b1;
					s_d.st      = ST_IDLE;
				end else begin
					s_d.mem_req  = 1'b1;
					s_d.mem_addr = desc_addr(s_q.base, s_q.idx, DESC_BUFADR_OFS);
					s_d.st       = ST_BUFADR;
				end
			end
			ST_BUFADR: begin
				s_d.buf_addr  = bus.mem_rdata;
				// write back pid and real count, hand ownership back
				s_d.mem_req   = 1'b1;
				s_d.mem_we    = 1'b1;
				s_d.mem_addr  = desc_addr(s_q.base, s_q.idx, DESC_STATUS_OFS);
				s_d.mem_wdata = {1'b0, s_q.status[DESC_TOGGLE_BIT], xfer_pid,
				                 xfer_actual_count};
				s_d.status    = s_d.mem_wdata;
				s_d.st        = ST_DONE;
			end
			default: begin
				s_d.done = 1'b1;
				s_d.st   = ST_IDLE;
			end
		endcase
		// busy looks ahead so that it drops in the cycle done rises
		s_d.busy = (s_d.st != ST_IDLE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// everything idle, resistors released, table at address zero
			s_q <= '{pu: 1'b0, dp_pd: 1'b0, dm_pd: 1'b0,
			         st: ST_IDLE, base: BASE_RESET, idx: 6'h00,
			         status: 16'h0000, buf_addr: DMA_ADDR_RESET,
			         src_ep: 4'h0, dest_ep: 4'h0,
			         mem_req: 1'b0, mem_we: 1'b0,
			         mem_addr: DMA_ADDR_RESET, mem_wdata: 16'h0000,
			         done: 1'b0, skipped: 1'b0, busy: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	// bus resistor pins
	assign dplus_pullup_on       = s_q.pu;
	assign dplus_pulldown_on     = s_q.dp_pd;
	assign dminus_pulldown_on    = s_q.dm_pd;

	// fetch progress, skipped is a one-cycle pulse
	assign xfer_busy             = s_q.busy;
	assign xfer_skipped          = s_q.skipped;

	// memory port, one word per request and no wait states
	assign bus.mem_req           = s_q.mem_req;
	assign bus.mem_we            = s_q.mem_we;
	assign bus.mem_addr          = s_q.mem_addr;
	assign bus.mem_wdata         = s_q.mem_wdata;

	// completion report; the done fields stand until the next take
	assign bus.xfer_done         = s_q.done;
	assign bus.done_status       = s_q.status;
	assign bus.done_src_ep       = s_q.src_ep;
	assign bus.done_dest_ep      = s_q.dest_ep;
	assign bus.done_buf_addr     = s_q.buf_addr;
	assign bus.done_owned_by_sw  = ~s_q.status[DESC_OWN_BIT];
endmodule : usb_bdt_engine

// File: hdl/usb_bdt_software.sv
`timescale 1ns/1ps
// software side: holds control bits, table pointer and answers table reads
module usb_bdt_software
	import usb_bdt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	usb_bdt_if.other         bus,
	input  wire logic        cfg_we,
	input  wire logic [7:0]  cfg_ctrl,
	input  wire logic [7:0]  cfg_otg,
	input  wire logic [7:0]  cfg_base,
	input  wire logic [1:0]  cfg_pingpong,
	input  wire logic        vbus_high,
	input  wire logic        req,
	input  wire logic [3:0]  req_ep,
	input  wire logic        req_tx,
	input  wire logic        req_odd,
	input  wire logic [3:0]  req_dest_ep,
	input  wire logic [3:0]  req_src_ep,
	input  wire logic [15:0] mem_data_in,
	output logic             done_seen
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  otg;
		logic [7:0]  base;
		logic [1:0]  pp;
		logic        vbus;
		logic        req;
		logic [3:0]  ep;
		logic        tx;
		logic        odd;
		logic [3:0]  dest;
		logic [3:0]  src;
		logic [15:0] rdata;
		logic        seen;
	} sw_t;

	sw_t s_q;
	sw_t s_d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d      = s_q;
		s_d.req  = 1'b0;
		s_d.vbus = vbus_high;
		s_d.rdata = mem_data_in;
		s_d.seen = bus.xfer_done;
		if (cfg_we) begin
			// enable and pull-up bits cleared from any write made while vbus is low
			s_d.ctrl = vbus_high ? cfg_ctrl : (cfg_ctrl & 8'hfe);
			s_d.otg  = vbus_high ? cfg_otg : (cfg_otg & 8'h7f);
			s_d.base = cfg_base;
			s_d.pp   = cfg_pingpong;
		end
		if (req && !bus.xfer_req) begin
			s_d.req  = 1'b1;
			s_d.ep   = req_ep;
			s_d.tx   = req_tx;
			s_d.odd  = req_odd;
			s_d.dest = req_dest_ep;
			s_d.src  = req_src_ep;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{ctrl: 8'h00, otg: 8'h00, base: BASE_RESET, pp: 2'h0, vbus: 1'b0,
			         req: 1'b0, ep: 4'h0, tx: 1'b0, odd: 1'b0, dest: 4'h0, src: 4'h0,
			         rdata: 16'h0000, seen: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.module_enable_bit        = s_q.ctrl[CTRL_MODULE_ENABLE_BIT];
	assign bus.module_power_bit         = s_q.ctrl[CTRL_MODULE_POWER_BIT];
	assign bus.host_role_enable         = s_q.ctrl[CTRL_HOST_ROLE_BIT];
	assign bus.otg_resistor_ctrl_enable = s_q.otg[OTG_CTRL_ENABLE_BIT];
	assign bus.dplus_pullup_ctrl        = s_q.otg[OTG_DPLUS_PU_BIT];
	assign bus.dplus_pulldown_ctrl      = s_q.otg[OTG_DPLUS_PD_BIT];
	assign bus.dminus_pulldown_ctrl     = s_q.otg[OTG_DMINUS_PD_BIT];
	assign bus.vbus_session_valid       = s_q.vbus;
	assign bus.table_base_pointer       = s_q.base;
	assign bus.pingpong_mode            = s_q.pp;
	assign bus.xfer_req                 = s_q.req;
	assign bus.xfer_ep                  = s_q.ep;
	assign bus.xfer_tx                  = s_q.tx;
	assign bus.xfer_odd                 = s_q.odd;
	assign bus.token_dest_ep            = s_q.dest;
	assign bus.rx_src_ep                = s_q.src;
	assign bus.mem_rdata                = s_q.rdata;
	assign done_seen                    = s_q.seen;
endmodule : usb_bdt_software

// File: testbench/usb_bdt_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// resistor control and descriptor fetch checks
// ----------------------------------------------------------------
module usb_bdt_sva
	import usb_bdt_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        module_enable_bit,
	input wire logic        module_power_bit,
	input wire logic        host_role_enable,
	input wire logic        otg_resistor_ctrl_enable,
	input wire logic        dplus_pullup_ctrl,
	input wire logic        dplus_pulldown_ctrl,
	input wire logic        dminus_pulldown_ctrl,
	input wire logic        vbus_session_valid,
	input wire logic [7:0]  table_base_pointer,
	input wire logic        xfer_req,
	input wire logic [3:0]  token_dest_ep,
	input wire logic [3:0]  rx_src_ep,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic        xfer_done,
	input wire logic [3:0]  done_src_ep,
	input wire logic [3:0]  done_dest_ep,
	input wire logic        done_owned_by_sw,
	input wire logic        xfer_busy,
	input wire logic        xfer_skipped,
	input wire logic        dplus_pullup_on,
	input wire logic        dplus_pulldown_on,
	input wire logic        dminus_pulldown_on
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// a request only counts when the fetch is idle; busy requests are dropped
	sequence s_take;
		xfer_req && !xfer_busy;
	endsequence
	// the own bit is sampled on the edge after the take, as the engine sees it
	sequence s_owned;
		s_take ##1 mem_rdata[DESC_OWN_BIT];
	endsequence
	sequence s_free;
		s_take ##1 !mem_rdata[DESC_OWN_BIT];
	endsequence

	chk_pullup_direct: assert property (
		!otg_resistor_ctrl_enable && vbus_session_valid && module_enable_bit
		&& module_power_bit |=> dplus_pullup_on) else $error("pull-up stayed off");
	chk_pullup_otg: assert property (
		otg_resistor_ctrl_enable && vbus_session_valid
		|=> dplus_pullup_on == $past(dplus_pullup_ctrl)) else $error("pull-up ignores otg bit");
	chk_pullup_vbus: assert property (
		!vbus_session_valid |=> !dplus_pullup_on) else $error("pull-up on without vbus");
	chk_pulldown_host: assert property (
		!otg_resistor_ctrl_enable |=> dplus_pulldown_on == $past(host_role_enable)
		&& dminus_pulldown_on == $past(host_role_enable)) else $error("pull-downs not host");
	chk_pulldown_otg: assert property (
		otg_resistor_ctrl_enable |=> dplus_pulldown_on == $past(dplus_pulldown_ctrl)
		&& dminus_pulldown_on == $past(dminus_pulldown_ctrl)) else $error("pull-downs wrong");
	chk_status_addr: assert property (
		s_take |=> mem_req && !mem_we && mem_addr[15:9] == $past(table_base_pointer[7:1])
		&& mem_addr[8] == 1'b0 && mem_addr[1:0] == 2'h0) else $error("status address wrong");
	chk_bufadr_next: assert property (
		s_owned |=> mem_req && !mem_we
		&& mem_addr == $past(mem_addr) + 16'h0002) else $error("buffer word address wrong");
	// write-back frees the descriptor, then completion follows a cycle later
	chk_owned_writeback: assert property (
		s_owned |-> ##2 (mem_req && mem_we && !mem_wdata[DESC_OWN_BIT]
		&& mem_addr == $past(mem_addr, 2)) ##1 (xfer_done && done_owned_by_sw))
		else $error("owned descriptor not written back");
	chk_skip_free: assert property (
		s_free |=> xfer_skipped && !mem_req)
		else $error("free descriptor not skipped");
	chk_host_ep0: assert property (
		(s_take and host_role_enable) |=> mem_addr[8:4] == 5'h00) else $error("host left ep0");
	chk_host_eps: assert property (
		xfer_done && host_role_enable |-> done_src_ep == rx_src_ep
		&& done_dest_ep == token_dest_ep) else $error("host endpoint report wrong");
endmodule : usb_bdt_sva

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import usb_bdt_pkg::*;
	logic        clk, arst_n, cfg_we, vbus_high, req, req_tx, req_odd, done_seen;
	logic        dplus_pullup_on, dplus_pulldown_on, dminus_pulldown_on, xfer_busy, xfer_skipped;
	logic [7:0]  cfg_ctrl, cfg_otg, cfg_base, base_v;
	logic [1:0]  cfg_pingpong, mode_v;
	logic [3:0]  req_ep, req_dest_ep, req_src_ep, xfer_pid;
	logic [9:0]  xfer_actual_count;
	logic [15:0] mem_data_in, stat_w, buf_w;
	logic        host_v;
	int          checked, fails;
	logic [7:0]  c_tab [9] = '{8'h03, 8'h01, 8'h08, 8'h03, 8'h00, 8'h08, 8'h00, 8'h03, 8'h00};
	logic [7:0]  o_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h84, 8'h24, 8'h14, 8'h00, 8'h84};
	logic [8:0]  v_tab = 9'b001111111;

	usb_bdt_if bus();
	usb_bdt_engine u_usb_bdt_engine (.clk(clk), .arst_n(arst_n), .bus(bus),
		.xfer_actual_count(xfer_actual_count), .xfer_pid(xfer_pid),
		.dplus_pullup_on(dplus_pullup_on), .dplus_pulldown_on(dplus_pulldown_on),
		.dminus_pulldown_on(dminus_pulldown_on), .xfer_busy(xfer_busy),
		.xfer_skipped(xfer_skipped));
	usb_bdt_software u_usb_bdt_software (.clk(clk), .arst_n(arst_n), .bus(bus),
		.cfg_we(cfg_we), .cfg_ctrl(cfg_ctrl), .cfg_otg(cfg_otg), .cfg_base(cfg_base),
		.cfg_pingpong(cfg_pingpong), .vbus_high(vbus_high), .req(req), .req_ep(req_ep),
		.req_tx(req_tx), .req_odd(req_odd), .req_dest_ep(req_dest_ep),
		.req_src_ep(req_src_ep), .mem_data_in(mem_data_in), .done_seen(done_seen));
	usb_bdt_sva u_usb_bdt_sva (.clk(clk), .arst_n(arst_n),
		.module_enable_bit(bus.module_enable_bit), .module_power_bit(bus.module_power_bit),
		.host_role_enable(bus.host_role_enable),
		.otg_resistor_ctrl_enable(bus.otg_resistor_ctrl_enable),
		.dplus_pullup_ctrl(bus.dplus_pullup_ctrl), .dplus_pulldown_ctrl(bus.dplus_pulldown_ctrl),
		.dminus_pulldown_ctrl(bus.dminus_pulldown_ctrl),
		.vbus_session_valid(bus.vbus_session_valid), .table_base_pointer(bus.table_base_pointer),
		.xfer_req(bus.xfer_req), .token_dest_ep(bus.token_dest_ep), .rx_src_ep(bus.rx_src_ep),
		.mem_req(bus.mem_req), .mem_we(bus.mem_we), .mem_addr(bus.mem_addr),
		.mem_wdata(bus.mem_wdata), .mem_rdata(bus.mem_rdata), .xfer_done(bus.xfer_done),
		.done_src_ep(bus.done_src_ep), .done_dest_ep(bus.done_dest_ep),
		.done_owned_by_sw(bus.done_owned_by_sw), .xfer_busy(xfer_busy),
		.xfer_skipped(xfer_skipped), .dplus_pullup_on(dplus_pullup_on),
		.dplus_pulldown_on(dplus_pulldown_on), .dminus_pulldown_on(dminus_pulldown_on));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// the software end registers memory data, so the status word must stand
	// before the take and the buffer word is loaded on the take edge itself
	always @(posedge clk) begin
		mem_data_in <= (bus.xfer_req & ~xfer_busy) ? buf_w : stat_w;
	end

	function automatic logic [5:0] map_idx(input logic [1:0] m, input logic [3:0] e,
		input logic t, input logic o);
		case (m)
			2'h0: map_idx = {1'b0, e, t};
			2'h1: map_idx = (e == 4'h0) ? (t ? 6'h02 : {5'h00, o}) : {1'b0, e, t} + 6'h01;
			2'h2: map_idx = {e, t, o};
			default: map_idx = (e == 4'h0) ? {5'h00, t} : {e, t, o} - 6'h02;
		endcase
	endfunction : map_idx

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic set_cfg(input logic [7:0] ctrl, otg, base, input logic [1:0] pp);
		base_v = base;
		mode_v = pp;
		host_v = ctrl[3];
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_ctrl <= ctrl;
		cfg_otg <= otg;
		cfg_base <= base;
		cfg_pingpong <= pp;
		@(posedge clk);
		cfg_we <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : set_cfg

	// vbus is raised first because enable writes are masked without it
	task automatic res_case(input logic [7:0] ctrl, otg, input logic vb);
		@(posedge clk);
		vbus_high <= 1'b1;
		set_cfg(ctrl, otg, 8'h00, 2'h0);
		vbus_high <= vb;
		repeat (4) @(posedge clk);
		#1;
		check("pull-up", {15'h0, vb & (otg[2] ? otg[7] : ctrl[0] & ctrl[1])}, {15'h0, dplus_pullup_on});
		check("pull-downs", {14'h0, otg[2] ? otg[5:4] : {2{ctrl[3]}}}, {14'h0, dplus_pulldown_on, dminus_pulldown_on});
	endtask : res_case

	task automatic xfer(input logic [3:0] ep, input logic tx, odd, own, input logic [15:0] ba);
		logic [5:0]  idx;
		logic [15:0] ra, wd;
		logic        rd, wr, sk, dn;
		idx = map_idx(mode_v, host_v ? 4'h0 : ep, tx, odd);
		stat_w = {own, odd, 4'h0, 10'h3c0};
		buf_w = ba;
		{rd, wr, sk, dn, ra, wd} = '0;
		@(posedge clk);
		req <= 1'b1;
		req_ep <= ep;
		req_tx <= tx;
		req_odd <= odd;
		req_dest_ep <= ~ep;
		req_src_ep <= ep ^ 4'h5;
		xfer_actual_count <= {idx, 4'h9};
		xfer_pid <= ep ^ 4'ha;
		@(posedge clk);
		req <= 1'b0;
		for (int n = 0; n < 20 && !dn && !sk; n++) begin
			@(posedge clk);
			#1;
			if (bus.mem_req === 1'b1 && bus.mem_we === 1'b0 && !rd) begin
				rd = 1'b1;
				ra = bus.mem_addr;
			end
			if (bus.mem_req === 1'b1 && bus.mem_we === 1'b1) begin
				wr = 1'b1;
				wd = bus.mem_wdata;
			end
			sk = (xfer_skipped === 1'b1);
			dn = (bus.xfer_done === 1'b1);
		end
		check("status address", {base_v[7:1], 9'h000} + {8'h00, idx, 2'b00}, ra);
		if (own) begin
			check("done", 16'h0001, {15'h0, dn});
			check("written status", {1'b0, odd, ep ^ 4'ha, idx, 4'h9}, wd);
			check("buffer address", ba, bus.done_buf_addr);
			@(posedge clk);
			#1;
			check("done seen", 16'h0001, {15'h0, done_seen});
		end else begin
			check("skipped", 16'h0001, {15'h0, sk});
			check("write seen", 16'h0000, {15'h0, wr});
		end
		if (host_v) begin
			check("source ep", {12'h0, ep ^ 4'h5}, {12'h0, bus.done_src_ep});
			check("dest ep", {12'h0, ~ep}, {12'h0, bus.done_dest_ep});
		end
		repeat (2) @(posedge clk);
	endtask : xfer

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict;
	end

	initial begin
		{arst_n, cfg_we, req, req_tx, req_odd, req_ep, req_dest_ep, req_src_ep} = '0;
		{cfg_ctrl, cfg_otg, cfg_base, cfg_pingpong, xfer_pid, xfer_actual_count} = '0;
		{mem_data_in, stat_w, buf_w, base_v, mode_v, host_v} = '0;
		{checked, fails} = '0;
		vbus_high = 1'b1;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 9; i++) res_case(c_tab[i], o_tab[i], v_tab[i]);
		$display("resistor control test done");
		for (int m = 0; m < 4; m++) begin
			set_cfg(8'h03, 8'h00, 8'h21, m[1:0]);
			xfer(4'h0, 1'b0, 1'b0, 1'b1, 16'h1234);
			xfer(4'h0, 1'b0, 1'b1, 1'b1, 16'h2468);
			xfer(4'h0, 1'b1, 1'b1, 1'b1, 16'h0ace);
			xfer(4'h5, 1'b0, 1'b1, 1'b1, 16'hfffe);
			xfer(4'hf, 1'b1, 1'b1, 1'b1, 16'h8000);
		end
		$display("descriptor index test done");
		// enable was written while vbus was low, so it must stay masked now
		vbus_high <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check("masked enable", 16'h0000, {15'h0, bus.module_enable_bit});
		check("masked pull-up", 16'h0000, {15'h0, dplus_pullup_on});
		xfer(4'h3, 1'b1, 1'b0, 1'b0, 16'h5555);
		$display("ownership test done");
		set_cfg(8'h0b, 8'h00, 8'hfe, 2'h2);
		xfer(4'h9, 1'b1, 1'b1, 1'b1, 16'hbeef);
		xfer(4'h4, 1'b0, 1'b0, 1'b1, 16'h0102);
		$display("host role test done");
		give_verdict;
	end
endmodule : testbench
